// File: hdl/pne_pkg.sv
`default_nettype none
package pne_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    // debounce settle time, hold time for entry, blink half periods
    localparam int unsigned DEBOUNCE_US     = 20_000;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOLD_MS         = 3_000;
    localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1_000);
    localparam int unsigned BLINK_HALF_MS   = 250;
    localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1_000);
    localparam int unsigned GAP_MS          = 1_000;
    localparam int unsigned GAP_CYC         = GAP_MS * (CLK_HZ / 1_000);
    localparam logic [3:0]  DIGIT_COUNT     = 4'h3;
    localparam logic [3:0]  CONFIRM_BLINKS  = 4'hA;
    localparam logic [3:0]  MAX_DIGIT       = 4'h9;
    localparam logic [3:0]  LEGACY_PREFIX   = 4'h1;
    localparam logic [15:0] PROG_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        PNE_IDLE    = 3'b000,
        PNE_ENTRY   = 3'b001,
        PNE_COUNT   = 3'b010,
        PNE_PRESSED = 3'b011,
        PNE_CONFIRM = 3'b100
    } pne_state_e;
endpackage
`default_nettype wire

// File: hdl/pne_entry.sv
`timescale 1ns/100ps
`default_nettype none
module pne_entry
    import pne_pkg::*;
#(
    parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
    parameter int unsigned HOLD     = HOLD_CYC,
    parameter int unsigned HALF     = BLINK_HALF_CYC,
    parameter int unsigned GAP      = GAP_CYC
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        switch_pressed,
    input  wire logic        remote_set,
    input  wire logic        remote_short,
    input  wire logic [15:0] remote_value,
    input  wire logic        boot_set,
    input  wire logic [15:0] boot_value,
    output logic             led,
    output logic [15:0]      program_number,
    output logic             manual_active,
    output logic             program_done
);
    ////////////////////////////////////////////////////////////////////
    // switch conditioning
    logic        sync_a;
    logic        sync_b;
    logic        sw;
    logic [31:0] deb_cnt;
    logic        sw_prev;
    logic        press;
    logic        release_ev;

    always_ff @(posedge clock) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= switch_pressed;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sw      <= 1'b0;
            deb_cnt <= '0;
            sw_prev <= 1'b0;
        end else begin
            sw_prev <= sw;
            if (sync_b == sw) begin
                deb_cnt <= '0;
            end else if (deb_cnt >= DEBOUNCE - 1) begin
                sw      <= sync_b;
                deb_cnt <= '0;
            end else begin
                deb_cnt <= deb_cnt + 32'h1;
            end
        end
    end

    assign press      = sw & ~sw_prev;
    assign release_ev = ~sw & sw_prev;

    ////////////////////////////////////////////////////////////////////
    // sequencing
    function automatic logic [15:0] prefix(input logic [11:0] low);
        prefix = {LEGACY_PREFIX, low};
    endfunction

    pne_state_e  state;
    logic [31:0] timer;
    logic [31:0] hold_cnt;
    logic [3:0]  blinks;
    logic [3:0]  digit_idx;
    logic [11:0] digits;
    logic        phase;

    always_ff @(posedge clock) begin
        if (reset) begin
            hold_cnt <= '0;
        end else if (sw && state == PNE_IDLE) begin
            if (hold_cnt < HOLD) begin
                hold_cnt <= hold_cnt + 32'h1;
            end
        end else begin
            hold_cnt <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state     <= PNE_IDLE;
            timer     <= '0;
            blinks    <= '0;
            digit_idx <= '0;
            digits    <= '0;
            phase     <= 1'b0;
            led       <= 1'b0;
        end else begin
            unique case (state)
                PNE_IDLE: begin
                    led <= 1'b0;
                    if (hold_cnt == HOLD - 1) begin
                        state <= PNE_ENTRY;
                        led   <= 1'b1;
                        timer <= '0;
                        phase <= 1'b1;
                    end
                end
                PNE_ENTRY: begin
                    // blink until released
                    if (timer >= HALF - 1) begin
                        timer <= '0;
                        led   <= ~led;
                    end else begin
                        timer <= timer + 32'h1;
                    end
                    if (release_ev) begin
                        state     <= PNE_COUNT;
                        digit_idx <= '0;
                        blinks    <= '0;
                        timer     <= '0;
                        phase     <= 1'b0;
                        led       <= 1'b0;
                    end
                end
                PNE_COUNT: begin
                    if (press) begin
                        digits    <= {digits[7:0], blinks};
                        digit_idx <= digit_idx + 4'h1;
                        state     <= PNE_PRESSED;
                        led       <= 1'b0;
                        timer     <= '0;
                    end else if (timer >= HALF - 1) begin
                        timer <= '0;
                        phase <= ~phase;
                        led   <= ~phase;
                        if (!phase) begin
                            // counter wraps after the highest digit
                            if (blinks == MAX_DIGIT) begin
                                blinks <= 4'h1;
                            end else begin
                                blinks <= blinks + 4'h1;
                            end
                        end
                    end else begin
                        timer <= timer + 32'h1;
                    end
                end
                PNE_PRESSED: begin
                    if (release_ev) begin
                        timer  <= '0;
                        phase  <= 1'b0;
                        blinks <= '0;
                        led    <= 1'b0;
                        if (digit_idx == DIGIT_COUNT) begin
                            state <= PNE_CONFIRM;
                        end else begin
                            state <= PNE_COUNT;
                        end
                    end
                end
                PNE_CONFIRM: begin
                    if (timer >= HALF - 1) begin
                        timer <= '0;
                        phase <= ~phase;
                        led   <= ~phase;
                        if (phase) begin
                            blinks <= blinks + 4'h1;
                            if (blinks == CONFIRM_BLINKS - 4'h1) begin
                                state <= PNE_IDLE;
                            end
                        end
                    end else begin
                        timer <= timer + 32'h1;
                    end
                end
                default: begin
                    state <= PNE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program number store
    logic manual_commit;
    assign manual_commit = (state == PNE_PRESSED) && release_ev
                           && (digit_idx == DIGIT_COUNT);

    always_ff @(posedge clock) begin
        if (reset) begin
            program_number <= PROG_RESET;
            program_done   <= 1'b0;
        end else begin
            program_done <= 1'b0;
            if (manual_commit) begin
                program_number <= prefix(digits);
                program_done   <= 1'b1;
            end else if (remote_set) begin
                if (remote_short) begin
                    program_number <= prefix(remote_value[11:0]);
                end else begin
                    program_number <= remote_value;
                end
                program_done <= 1'b1;
            end else if (boot_set) begin
                program_number <= boot_value;
                program_done   <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            manual_active <= 1'b0;
        end else begin
            manual_active <= (state != PNE_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_third_release;
        state == PNE_PRESSED && release_ev && digit_idx == DIGIT_COUNT;
    endsequence

    chk_manual_prefix: assert property (
        @(posedge clock) disable iff (reset)
        s_third_release |=> program_number == {4'h1, $past(digits)})
        else $error("manual number lacks leading one");

    chk_confirm_enter: assert property (
        @(posedge clock) disable iff (reset)
        s_third_release |=> state == PNE_CONFIRM)
        else $error("no confirm after third digit");

    chk_remote_short: assert property (
        @(posedge clock) disable iff (reset)
        remote_set && remote_short && !manual_commit |=>
        program_number == {4'h1, $past(remote_value[11:0])})
        else $error("short remote number not prefixed");

    chk_remote_full: assert property (
        @(posedge clock) disable iff (reset)
        remote_set && !remote_short && !manual_commit |=>
        program_number == $past(remote_value))
        else $error("remote value not stored");

    chk_boot_exact: assert property (
        @(posedge clock) disable iff (reset)
        boot_set && !remote_set && !manual_commit |=>
        program_number == $past(boot_value))
        else $error("bootloader value altered");

    chk_entry_hold: assert property (
        @(posedge clock) disable iff (reset)
        state == PNE_IDLE && hold_cnt == HOLD - 1 |=>
        state == PNE_ENTRY && led)
        else $error("hold did not enter manual mode");

    chk_press_capture: assert property (
        @(posedge clock) disable iff (reset)
        state == PNE_COUNT && press |=>
        state == PNE_PRESSED && digits[3:0] == $past(blinks))
        else $error("press did not capture digit");

    chk_digit_limit: assert property (
        @(posedge clock) disable iff (reset)
        digit_idx <= DIGIT_COUNT)
        else $error("too many digits");
endmodule
`default_nettype wire

// File: tb/pne_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module pne_switch_model (
    input  wire logic clock,
    input  wire logic want_pressed,
    output logic      switch_pressed
);
    logic [1:0] bounce;
    logic       last;

    initial begin
        switch_pressed = 1'b0;
        bounce = 2'h0;
        last = 1'b0;
    end

    // contacts chatter for three cycles after every change of the plunger
    always @(posedge clock) begin
        if (want_pressed != last) begin
            last <= want_pressed;
            bounce <= 2'h3;
        end
        if (bounce != 2'h0) begin
            bounce <= bounce - 2'h1;
            switch_pressed <= ~switch_pressed;
        end else begin
            switch_pressed <= last;
        end
    end
endmodule
`default_nettype wire

// File: tb/test_adapter_program_number_entry.sv
`timescale 1ns/100ps
`default_nettype none
module test_adapter_program_number_entry
    import pne_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        want = 1'b0;
    logic        sw;
    logic        remote_set = 1'b0;
    logic        remote_short = 1'b0;
    logic [15:0] remote_value = 16'h0000;
    logic        boot_set = 1'b0;
    logic [15:0] boot_value = 16'h0000;
    logic        led;
    logic [15:0] program_number;
    logic        manual_active;
    logic        program_done;
    int          err_count = 0;
    int          num_checks = 0;

    always #50 clock = ~clock;

    pne_switch_model u_sw (.clock(clock), .want_pressed(want),
        .switch_pressed(sw));

    pne_entry #(.DEBOUNCE(4), .HOLD(50), .HALF(8), .GAP(1)) u_dut (
        .clock(clock), .reset(reset), .switch_pressed(sw),
        .remote_set(remote_set), .remote_short(remote_short),
        .remote_value(remote_value), .boot_set(boot_set),
        .boot_value(boot_value), .led(led),
        .program_number(program_number), .manual_active(manual_active),
        .program_done(program_done));

    ////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one store request; the new number and the done pulse follow a cycle on
    task automatic send(input logic rs, input logic bs, input logic sh,
                        input logic [15:0] rv, input logic [15:0] bv,
                        input logic [15:0] exp);
        remote_set = rs;
        boot_set = bs;
        remote_short = sh;
        remote_value = rv;
        boot_value = bv;
        tick(1);
        remote_set = 1'b0;
        boot_set = 1'b0;
        check("program_number", program_number, exp);
        check("program_done", {15'h0, program_done}, 16'h1);
        tick(1);
        check("program_done low", {15'h0, program_done}, 16'h0);
    endtask

    task automatic short_press;
        logic seen;
        seen = 1'b0;
        want = 1'b1;
        tick(30);
        want = 1'b0;
        repeat (60) begin
            tick(1);
            seen = seen | manual_active;
        end
        check("short press", {15'h0, seen}, 16'h0);
    endtask

    task automatic manual_entry;
        int digits [3] = '{9, 1, 3};
        int rises;
        int dones;
        logic prev;
        want = 1'b1;
        for (int i = 0; i < 200 && manual_active !== 1'b1; i++)
            tick(1);
        check("manual_active", {15'h0, manual_active}, 16'h1);
        check("entry led", {15'h0, led}, 16'h1);
        want = 1'b0;
        foreach (digits[d]) begin
            tick(12);
            repeat (digits[d]) @(posedge led);
            tick(1);
            want = 1'b1;
            tick(20);
            want = 1'b0;
        end
        rises = 0;
        dones = 0;
        prev = led;
        repeat (400) begin
            tick(1);
            if (led && !prev)
                rises++;
            if (program_done)
                dones++;
            prev = led;
        end
        check("number", program_number, {LEGACY_PREFIX, 12'h913});
        check("done pulses", 16'(dones), 16'h1);
        check("confirm blinks", 16'(rises), 16'h000A);
        check("manual end", {15'h0, manual_active}, 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        reset = 1'b0;
        check("reset number", program_number, 16'h0000);
        check("reset led", {15'h0, led}, 16'h0);
        send(1'b1, 1'b0, 1'b1, 16'h0247, 16'h0000, 16'h1247);
        send(1'b1, 1'b0, 1'b1, 16'h0999, 16'h0000, 16'h1999);
        send(1'b1, 1'b0, 1'b0, 16'h2013, 16'h0000, 16'h2013);
        send(1'b0, 1'b1, 1'b1, 16'h0000, 16'h0555, 16'h0555);
        send(1'b1, 1'b1, 1'b1, 16'h0321, 16'h4444, 16'h1321);
        short_press();
        manual_entry();
        tally_and_finish();
    end

    initial begin
        #500_000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
